/* File: logic/upc_defines.svh */
`ifndef UPC_DEFINES_SVH
`define UPC_DEFINES_SVH

// clock and carrier
`define UPC_CLK_HZ        100000000
`define UPC_PWM_MOD       11'h5DC
`define UPC_PWM_HALF      11'h2EE
`define UPC_PWM_LAST      11'h5DB

// slow timers, periods in milliseconds, start-up count in ticks
`define UPC_TICK_MS       140
`define UPC_PROT_MS       4
`define UPC_STARTUP_TICKS 5'h15

// decimation and filtering
`define UPC_DECIM_LAST    4'hF
`define UPC_MA_SHIFT      4
`define UPC_PI_SHIFT      16

// register indices
`define UPC_REG_CTRL      4'h0
`define UPC_REG_DELAY     4'h1
`define UPC_REG_WA        4'h2
`define UPC_REG_WB        4'h3
`define UPC_REG_THRESH    4'h4
`define UPC_REG_CMP_INV   4'h5
`define UPC_REG_CMP_BST   4'h6
`define UPC_REG_CMP_PFC   4'h7
`define UPC_REG_STATUS    4'h8
`define UPC_REG_TEMP      4'h9
`define UPC_REG_CHG_AVG   4'hA

// field positions
`define UPC_CTRL_RUN      0
`define UPC_CTRL_CLR      1
`define UPC_ST_FAIL       0
`define UPC_ST_FLT        3
`define UPC_ST_AUX        6
`define UPC_ST_ANY        7

`endif

/* File: logic/upc_pkg.sv */
`default_nettype none
package upc_pkg;
	// sample delay timer states
	typedef enum logic [1:0] {
		UPC_DLY_IDLE = 2'b01,
		UPC_DLY_RUN  = 2'b10
	} upc_dly_state_t;
endpackage
`default_nettype wire

/* File: logic/upc_pwm_core.sv */
`include "upc_defines.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// pi compensator, 32-bit integrator, total gain, anti-windup
module upc_pi #(
	parameter logic signed [15:0] KP  = 16'sh0100,
	parameter logic signed [15:0] KI  = 16'sh0010,
	parameter logic signed [15:0] KT  = 16'sh4000,
	parameter logic signed [15:0] LIM = 16'sh7000
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	// update strobe and error
	input  wire logic               upd,
	input  wire logic signed [15:0] err,
	// result
	output logic signed [15:0]      out_q
);
	logic signed [31:0] integ_q;
	logic signed [31:0] sum;
	logic signed [47:0] scl;
	logic signed [31:0] q;
	logic               hi;
	logic               lo;
	logic               sat_q;

	// proportional plus integral, scaled by the total gain
	assign sum = (KP * err) + integ_q;
	assign scl = sum * KT;
	assign q   = scl[47:`UPC_PI_SHIFT];
	assign hi  = q > LIM;
	assign lo  = q < -LIM;

	// integrator frozen while the output sits at its limit
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			integ_q <= '0;
			sat_q   <= 1'b0;
			out_q   <= '0;
		end else if (upd) begin
			if (!sat_q)
				integ_q <= integ_q + (KI * err);
			sat_q <= hi | lo;
			out_q <= hi ? LIM : (lo ? -LIM : q[15:0]);
		end
	end
endmodule // upc_pi

////////////////////////////////////////////////////////////////////////////////
// Operation
// - center-aligned carrier, modulo 1500 clocks
// - compare values load at full-cycle reload
// - reload sync starts programmed delay timer
// - delay expiry issues start of conversion
// - end of conversion drives loop updates
// - asserted fault disables its pwm pair
// - one overcurrent counter per subsystem
// - each fault event adds weight A
// - each conversion end subtracts weight B
// - fail only when counter exceeds threshold
// - booster second compare is 1500 minus first
// - booster drives separated by 4 ms guard at full duty
// - booster update every sixteenth sample
// - charger loop updates once per sixteen samples
// - charger samples averaged before the loop
// - charger integrator frozen at output limit
// - 21 ticks of 140 ms before aux stable
// - pi with 32-bit integrator, total gain
// - outer voltage output feeds inner current loop
// - rectifier inner loop uses absolute values
// - temperature conversion end stores result
// - fault 0 inverter, 1 rectifier, 2 booster
// - channels 0-1 inverter, 2-3 booster, 4-5 rectifier
module upc_pwm_core #(
	parameter int TICK_CYC = `UPC_TICK_MS * (`UPC_CLK_HZ / 1000),
	parameter int PROT_CYC = `UPC_PROT_MS * (`UPC_CLK_HZ / 1000),
	parameter int ACC_W    = 24
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	// register port
	input  wire logic [3:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [31:0]             reg_rdata,
	// pins from the power stage and converters
	input  wire logic [2:0]         fault_in,
	input  wire logic               conv_done,
	input  wire logic               temp_done,
	// converter results
	input  wire logic signed [15:0] inv_vref,
	input  wire logic signed [15:0] inv_vout,
	input  wire logic signed [15:0] inv_iload,
	input  wire logic signed [15:0] pfc_iset,
	input  wire logic signed [15:0] pfc_iline,
	input  wire logic signed [15:0] bst_vref,
	input  wire logic signed [15:0] bst_vrail,
	input  wire logic signed [15:0] chg_vset,
	input  wire logic signed [15:0] chg_vbat,
	input  wire logic [15:0]        temp_data,
	// outputs
	output logic [5:0]              main_switch_modulator,
	output logic                    conv_start,
	output logic                    loop_update,
	output logic                    aux_stable,
	output logic                    fail,
	output logic signed [15:0]      ctl_inv,
	output logic signed [15:0]      ctl_pfc,
	output logic signed [15:0]      ctl_bst,
	output logic signed [15:0]      ctl_chg
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	logic [31:0]            rdata_q;
	logic                   run_q;
	logic [15:0]            delay_q;
	logic [15:0]            wa_q;
	logic [15:0]            wb_q;
	logic [ACC_W-1:0]       thresh_q;
	logic [10:0]            cmp_sw_q [3];
	logic [10:0]            cmp_act_q [3];
	logic [10:0]            ph_q;
	logic [10:0]            tri_w;
	logic [11:0]            tri2;
	logic [10:0]            cmp3;
	logic                   reload;
	logic [5:0]             raw;
	logic [5:0]             off;
	logic [5:0]             nxt;
	logic [5:0]             pwm_q;
	logic [23:0]            guard_q;
	logic                   last_q;
	logic                   blk2;
	logic                   blk3;
	logic [2:0]             flt_m_q;
	logic [2:0]             flt_s_q;
	logic [2:0]             flt_d_q;
	logic [2:0]             flt_ev;
	logic [2:0]             cd_q;
	logic [2:0]             td_q;
	logic                   eoc;
	logic                   tev;
	logic [ACC_W-1:0]       acc_q [3];
	logic [2:0]             over;
	logic                   fail_q;
	logic                   clr;
	upc_pkg::upc_dly_state_t dly_q;
	logic [15:0]            dcnt_q;
	logic                   soc_q;
	logic                   upd_q;
	logic                   upd2_q;
	logic [3:0]             dec_q;
	logic                   decim;
	logic                   decim_q;
	logic signed [19:0]     ma_q;
	logic signed [19:0]     ma_sum;
	logic signed [15:0]     avg_q;
	logic [15:0]            temp_q;
	logic [23:0]            div_q;
	logic                   tick;
	logic [4:0]             ticks_q;
	logic                   aux_q;
	logic signed [15:0]     iset;

	////////////////////////////////////////////////////////////////////////////
	// register writes
	assign clr = reg_wr && reg_addr == `UPC_REG_CTRL && reg_wdata[`UPC_CTRL_CLR];
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run_q    <= 1'b0;
			delay_q  <= '0;
			wa_q     <= '0;
			wb_q     <= '0;
			thresh_q <= '0;
			for (int i = 0; i < 3; i++)
				cmp_sw_q[i] <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				`UPC_REG_CTRL:    run_q    <= reg_wdata[`UPC_CTRL_RUN];
				`UPC_REG_DELAY:   delay_q  <= reg_wdata[15:0];
				`UPC_REG_WA:      wa_q     <= reg_wdata[15:0];
				`UPC_REG_WB:      wb_q     <= reg_wdata[15:0];
				`UPC_REG_THRESH:  thresh_q <= reg_wdata[ACC_W-1:0];
				`UPC_REG_CMP_INV: cmp_sw_q[0] <= reg_wdata[10:0];
				`UPC_REG_CMP_BST: cmp_sw_q[1] <= reg_wdata[10:0];
				`UPC_REG_CMP_PFC: cmp_sw_q[2] <= reg_wdata[10:0];
				default: ;
			endcase
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			rdata_q <= '0;
		else if (!reg_rd)
			rdata_q <= '0;
		else begin
			case (reg_addr)
				`UPC_REG_CTRL:    rdata_q <= {31'h0, run_q};
				`UPC_REG_DELAY:   rdata_q <= {16'h0, delay_q};
				`UPC_REG_WA:      rdata_q <= {16'h0, wa_q};
				`UPC_REG_WB:      rdata_q <= {16'h0, wb_q};
				`UPC_REG_THRESH:  rdata_q <= 32'(thresh_q);
				`UPC_REG_CMP_INV: rdata_q <= {21'h0, cmp_sw_q[0]};
				`UPC_REG_CMP_BST: rdata_q <= {21'h0, cmp_sw_q[1]};
				`UPC_REG_CMP_PFC: rdata_q <= {21'h0, cmp_sw_q[2]};
				`UPC_REG_STATUS:  rdata_q <= {24'h0, fail_q, aux_q, flt_s_q, over};
				`UPC_REG_TEMP:    rdata_q <= {16'h0, temp_q};
				`UPC_REG_CHG_AVG: rdata_q <= {16'h0, avg_q};
				default:          rdata_q <= '0;
			endcase
		end
	end
	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// carrier phase, period 1500 clocks, triangle folded at mid-period
	assign reload = ph_q == `UPC_PWM_LAST;
	always_ff @(posedge core_clk) begin
		if (sys_rst || reload)
			ph_q <= '0;
		else
			ph_q <= ph_q + 11'h001;
	end
	assign tri_w = (ph_q < `UPC_PWM_HALF) ? `UPC_PWM_HALF - ph_q : ph_q - `UPC_PWM_HALF;
	assign tri2  = {tri_w, 1'b0};

	// compare shadows, taken only at the full-cycle reload
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 3; i++)
				cmp_act_q[i] <= '0;
		end else if (reload) begin
			for (int i = 0; i < 3; i++)
				cmp_act_q[i] <= (cmp_sw_q[i] > `UPC_PWM_MOD) ? `UPC_PWM_MOD : cmp_sw_q[i];
		end
	end

	// channel drives and pair gating
	assign cmp3 = `UPC_PWM_MOD - cmp_act_q[1];
	assign blk2 = guard_q != '0 && last_q;
	assign blk3 = guard_q != '0 && !last_q;
	always_comb begin
		raw[0] = tri2 < {1'b0, cmp_act_q[0]};
		raw[1] = !raw[0];
		raw[2] = tri2 < {1'b0, cmp_act_q[1]} && !blk2;
		raw[3] = !(tri2 < {1'b0, cmp3}) && !blk3;
		raw[4] = tri2 < {1'b0, cmp_act_q[2]};
		raw[5] = !raw[4];
		off    = {{2{flt_s_q[1]}}, {2{flt_s_q[2]}}, {2{flt_s_q[0]}}};
		nxt    = (run_q && !fail_q) ? raw & ~off : 6'h00;
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			pwm_q <= '0;
		else
			pwm_q <= nxt;
	end
	assign main_switch_modulator = pwm_q;

	// guard after a booster drive ends at full duty, never retriggered while running
	// (the blocked drive falling must not hand the guard back and forth)
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			guard_q <= '0;
			last_q  <= 1'b0;
		end else if (guard_q == '0 && cmp_act_q[1] == `UPC_PWM_MOD
				&& pwm_q[2] && !nxt[2]) begin
			guard_q <= 24'(PROT_CYC);
			last_q  <= 1'b0;
		end else if (guard_q == '0 && cmp_act_q[1] == `UPC_PWM_MOD
				&& pwm_q[3] && !nxt[3]) begin
			guard_q <= 24'(PROT_CYC);
			last_q  <= 1'b1;
		end else if (guard_q != '0)
			guard_q <= guard_q - 24'h000001;
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detect
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flt_m_q <= '0;
			flt_s_q <= '0;
			flt_d_q <= '0;
			cd_q    <= '0;
			td_q    <= '0;
		end else begin
			flt_m_q <= fault_in;
			flt_s_q <= flt_m_q;
			flt_d_q <= flt_s_q;
			cd_q    <= {cd_q[1:0], conv_done};
			td_q    <= {td_q[1:0], temp_done};
		end
	end
	assign flt_ev = flt_s_q & ~flt_d_q;
	assign eoc    = cd_q[1] && !cd_q[2];
	assign tev    = td_q[1] && !td_q[2];

	////////////////////////////////////////////////////////////////////////////
	// sample delay timer from reload sync to start of conversion
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dly_q  <= upc_pkg::UPC_DLY_IDLE;
			dcnt_q <= '0;
			soc_q  <= 1'b0;
		end else begin
			soc_q <= 1'b0;
			unique case (dly_q)
				upc_pkg::UPC_DLY_IDLE: if (reload && run_q) begin
					dcnt_q <= delay_q;
					dly_q  <= upc_pkg::UPC_DLY_RUN;
				end
				upc_pkg::UPC_DLY_RUN: if (dcnt_q == '0) begin
					soc_q <= 1'b1;
					dly_q <= upc_pkg::UPC_DLY_IDLE;
				end else
					dcnt_q <= dcnt_q - 16'h0001;
			endcase
		end
	end
	assign conv_start = soc_q;

	////////////////////////////////////////////////////////////////////////////
	// overcurrent accumulators, one per subsystem
	for (genvar g = 0; g < 3; g++) begin : g_acc
		logic [ACC_W:0] up;
		assign up = {1'b0, acc_q[g]} + (flt_ev[g] ? (ACC_W+1)'(wa_q) : '0);
		always_ff @(posedge core_clk) begin
			if (sys_rst)
				acc_q[g] <= '0;
			else if (eoc)
				acc_q[g] <= up[ACC_W] ? '1 :
					(up[ACC_W-1:0] > ACC_W'(wb_q) ? up[ACC_W-1:0] - ACC_W'(wb_q) : '0);
			else
				acc_q[g] <= up[ACC_W] ? '1 : up[ACC_W-1:0];
		end
		assign over[g] = acc_q[g] > thresh_q;
	end

	// sticky fail, a new cause wins over the clear
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			fail_q <= 1'b0;
		else if (|over)
			fail_q <= 1'b1;
		else if (clr)
			fail_q <= 1'b0;
	end
	assign fail = fail_q;

	////////////////////////////////////////////////////////////////////////////
	// loop strobes, decimation by 16, charger moving average
	assign decim  = eoc && dec_q == `UPC_DECIM_LAST;
	assign ma_sum = ma_q + 20'(chg_vbat);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			upd_q   <= 1'b0;
			upd2_q  <= 1'b0;
			decim_q <= 1'b0;
			dec_q   <= '0;
			ma_q    <= '0;
			avg_q   <= '0;
		end else begin
			upd_q   <= eoc;
			upd2_q  <= upd_q;
			decim_q <= decim;
			if (eoc) begin
				dec_q <= dec_q + 4'h1;
				ma_q  <= decim ? '0 : ma_sum;
			end
			if (decim)
				avg_q <= ma_sum[19:`UPC_MA_SHIFT];
		end
	end
	assign loop_update = upd_q;

	// temperature result captured on its own conversion end
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			temp_q <= '0;
		else if (tev)
			temp_q <= temp_data;
	end

	////////////////////////////////////////////////////////////////////////////
	// compensators
	upc_pi u_inv_v (.core_clk(core_clk), .sys_rst(sys_rst), .upd(upd_q),
		.err(inv_vref - inv_vout), .out_q(iset));
	upc_pi u_inv_i (.core_clk(core_clk), .sys_rst(sys_rst), .upd(upd2_q),
		.err(iset - inv_iload), .out_q(ctl_inv));
	upc_pi u_pfc_i (.core_clk(core_clk), .sys_rst(sys_rst), .upd(upd_q),
		.err((pfc_iset < 0 ? -pfc_iset : pfc_iset)
			- (pfc_iline < 0 ? -pfc_iline : pfc_iline)), .out_q(ctl_pfc));
	upc_pi u_bst (.core_clk(core_clk), .sys_rst(sys_rst), .upd(decim_q),
		.err(bst_vref - bst_vrail), .out_q(ctl_bst));
	upc_pi u_chg (.core_clk(core_clk), .sys_rst(sys_rst), .upd(decim_q),
		.err(chg_vset - avg_q), .out_q(ctl_chg));

	////////////////////////////////////////////////////////////////////////////
	// start-up wait, 21 ticks of the slow timer
	assign tick = div_q == 24'(TICK_CYC - 1);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			div_q   <= '0;
			ticks_q <= '0;
			aux_q   <= 1'b0;
		end else begin
			div_q <= tick ? '0 : div_q + 24'h000001;
			if (tick && !aux_q) begin
				ticks_q <= ticks_q + 5'h01;
				if (ticks_q == `UPC_STARTUP_TICKS - 5'h01)
					aux_q <= 1'b1;
			end
		end
	end
	assign aux_stable = aux_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_sync;
		reload && run_q && dly_q == upc_pkg::UPC_DLY_IDLE;
	endsequence
	sequence s_expire;
		dly_q == upc_pkg::UPC_DLY_RUN && dcnt_q == '0;
	endsequence
	property p_carrier;
		reload |=> ph_q == '0 ##1 ph_q == 11'h001;
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier wrap");
	property p_shadow;
		!reload |=> $stable(cmp_act_q[0]) && $stable(cmp_act_q[1]);
	endproperty
	a_shadow: assert property (p_shadow) else $error("compare changed mid cycle");
	property p_delay_load;
		s_sync |=> dly_q == upc_pkg::UPC_DLY_RUN && dcnt_q == $past(delay_q);
	endproperty
	a_delay_load: assert property (p_delay_load) else $error("delay not loaded");
	property p_soc;
		s_expire |=> conv_start ##1 !conv_start;
	endproperty
	a_soc: assert property (p_soc) else $error("start of conversion missing");
	property p_fault;
		flt_s_q[0] |=> !main_switch_modulator[0] && !main_switch_modulator[1];
	endproperty
	a_fault: assert property (p_fault) else $error("inverter pair not disabled");
	property p_add;
		flt_ev[0] && !eoc && acc_q[0] < thresh_q |=> acc_q[0] == $past(acc_q[0]) + ACC_W'($past(wa_q));
	endproperty
	a_add: assert property (p_add) else $error("weight A not added");
	property p_sub;
		eoc && !flt_ev[1] && acc_q[1] > ACC_W'(wb_q) |=> acc_q[1] == $past(acc_q[1]) - ACC_W'($past(wb_q));
	endproperty
	a_sub: assert property (p_sub) else $error("weight B not subtracted");
	property p_fail;
		(|over) |=> fail ##1 !(|main_switch_modulator);
	endproperty
	a_fail: assert property (p_fail) else $error("fail not entered");
	property p_guard;
		guard_q != '0 && last_q |=> !main_switch_modulator[2];
	endproperty
	a_guard: assert property (p_guard) else $error("booster guard broken");
	property p_guard_b;
		guard_q != '0 && !last_q |=> !main_switch_modulator[3];
	endproperty
	a_guard_b: assert property (p_guard_b) else $error("booster second guard broken");
	property p_decim;
		decim |=> dec_q == '0 ##1 decim_q == 1'b0;
	endproperty
	a_decim: assert property (p_decim) else $error("decimation count");
	property p_aux;
		$rose(aux_stable) |-> $past(tick) && ticks_q == `UPC_STARTUP_TICKS;
	endproperty
	a_aux: assert property (p_aux) else $error("aux stable early");
	property p_temp;
		tev |=> temp_q == $past(temp_data);
	endproperty
	a_temp: assert property (p_temp) else $error("temperature not stored");
endmodule // upc_pwm_core

`default_nettype wire

/* File: tb/tb_top.sv */
`include "upc_defines.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic               core_clk, sys_rst, reg_wr, reg_rd, conv_done, temp_done, slow;
	logic               conv_start, loop_update, aux_stable, fail;
	logic               rd_pend = 1'b0;
	logic               cd_q = 1'b0;
	logic [2:0]         lu_sr = 3'h0;
	logic [3:0]         reg_addr;
	logic [31:0]        reg_wdata, reg_rdata;
	logic [31:0]        exp_q [$];
	logic [2:0]         fault_in;
	logic [5:0]         msm;
	logic [15:0]        temp_val, temp_data;
	logic signed [15:0] chg_val, ctl_inv, ctl_pfc, ctl_bst, ctl_chg, bst_q, chg_q;
	logic signed [15:0] res [7];
	int                 n_fail = 0;
	int                 n_tests = 0;
	int                 cyc = 0;
	int                 cs_t = 0;
	int                 nb = 0;
	int                 nc = 0;
	int                 cnt [6];

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	upc_pwm_core #(.TICK_CYC(20), .PROT_CYC(30)) dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_in(fault_in),
		.conv_done(conv_done), .temp_done(temp_done), .inv_vref(res[0]), .inv_vout(res[1]),
		.inv_iload(res[2]), .pfc_iset(res[3]), .pfc_iline(res[4]), .bst_vref(res[5]),
		.bst_vrail(res[6]), .chg_vset(res[0]), .chg_vbat(chg_val), .temp_data(temp_data),
		.main_switch_modulator(msm), .conv_start(conv_start), .loop_update(loop_update),
		.aux_stable(aux_stable), .fail(fail), .ctl_inv(ctl_inv), .ctl_pfc(ctl_pfc),
		.ctl_bst(ctl_bst), .ctl_chg(ctl_chg));

	upc_stage_model stage (
		.core_clk(core_clk), .conv_start(conv_start), .slow(slow), .temp_val(temp_val),
		.conv_done(conv_done), .temp_done(temp_done), .temp_data(temp_data), .res(res));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	// high cycles of each drive over one full carrier period
	task automatic count_pwm(input int pre);
		repeat (pre) @(posedge core_clk);
		cnt = '{default: 0};
		repeat (1500) begin
			@(posedge core_clk);
			foreach (cnt[b]) cnt[b] += msm[b];
		end
	endtask

	// one short overcurrent event on the inverter pin
	task automatic bump;
		@(posedge core_clk);
		fault_in <= 3'h1;
		repeat (4) @(posedge core_clk);
		fault_in <= 3'h0;
		repeat (6) @(posedge core_clk);
	endtask

	// expected high count of a channel over one triangle period
	function automatic int hi(input int c, input bit inv);
		int t;
		hi = 0;
		for (int p = 0; p < 1500; p++) begin
			t = (p > 750 ? p - 750 : 750 - p) * 2;
			hi += inv ? (t >= 1500 - c) : (t < c);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// read data, loop update, start-up and decimation watcher
	always @(posedge core_clk) begin
		rd_pend <= reg_rd;
		cd_q <= conv_done;
		lu_sr <= {lu_sr[1:0], conv_done & ~cd_q};
		cyc <= sys_rst ? 0 : cyc + 1;
		bst_q <= ctl_bst;
		chg_q <= ctl_chg;
		nb <= nb + int'(ctl_bst !== bst_q);
		nc <= nc + int'(ctl_chg !== chg_q);
		if (conv_start) cs_t <= cyc;
		if (rd_pend) chk("reg_rdata", reg_rdata, exp_q.pop_front());
		if (!sys_rst && (loop_update || lu_sr[2])) chk("loop_update", loop_update, lu_sr[2]);
		if (cyc == 419 || cyc == 420) chk("aux_stable", aux_stable, cyc == 420);
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		n_fail++;
		report_and_stop;
	end

	// main sequence
	initial begin : main
		logic [31:0] d;
		int          c [3];
		int          t0;
		int          pr;
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		fault_in = 3'h0;
		slow = 1'b0;
		chg_val = 16'sh0123;
		temp_val = 16'h0000;
		void'($urandom(32'h9F707E38));
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`UPC_REG_STATUS, 32'h0);
		rd(4'hB, 32'h0);
		for (int i = 1; i < 5; i++) begin
			d = $urandom;
			wr(4'(i), d);
			rd(4'(i), d & (i == 4 ? 32'h00FF_FFFF : 32'h0000_FFFF));
		end
		// compares per pair, then one measured period
		wr(`UPC_REG_WA, 32'h0);
		wr(`UPC_REG_DELAY, 32'h0);
		wr(`UPC_REG_WB, 32'h0);
		wr(`UPC_REG_THRESH, 32'h64);
		for (int i = 0; i < 3; i++) begin
			c[i] = 1 + $urandom % 1499;
			wr(4'(5 + i), 32'(c[i]));
		end
		wr(`UPC_REG_CTRL, 32'h1);
		count_pwm(3100);
		chk("inv_a", cnt[0], hi(c[0], 0));
		chk("inv_b", cnt[1], 1500 - hi(c[0], 0));
		chk("bst_a", cnt[2], hi(c[1], 0));
		chk("bst_b", cnt[3], hi(c[1], 1));
		chk("pfc_a", cnt[4], hi(c[2], 0));
		chk("pfc_b", cnt[5], 1500 - hi(c[2], 0));
		// full booster duty: oversized compare clamps, guard holds the second drive off
		wr(`UPC_REG_CMP_BST, 32'h7FF);
		count_pwm(1600);
		chk("bst_full", cnt[2], hi(1500, 0));
		chk("bst_guard", cnt[3], 1500 - 30);
		// trigger offset follows the programmed delay
		wr(`UPC_REG_DELAY, 32'h0);
		repeat (3000) @(posedge core_clk);
		t0 = cs_t;
		d = 1 + $urandom % 200;
		wr(`UPC_REG_DELAY, d);
		repeat (3000) @(posedge core_clk);
		chk("sample_delay", (cs_t - t0) % 1500, d);
		@(posedge core_clk iff conv_start);
		t0 = cyc;
		@(posedge core_clk iff conv_start);
		chk("trigger_period", cyc - t0, 1500);
		// each pin silences its own pair, and the inverter pair stays on for the other two pins
		for (int i = 0; i < 3; i++) begin
			pr = i == 1 ? 2 : i / 2;
			@(posedge core_clk);
			fault_in <= 3'(1 << i);
			count_pwm(4);
			chk("pair_off", cnt[2 * pr] + cnt[2 * pr + 1], 0);
			if (i != 0) chk("inv_on", cnt[0] + cnt[1], 1500);
			rd(`UPC_REG_STATUS, 32'h40 | (32'h8 << i));
			fault_in <= 3'h0;
		end
		// weighted bucket: 50 per event, threshold 100
		wr(`UPC_REG_WA, 32'd50);
		bump;
		chk("isolated", fail, 1'b0);
		bump;
		bump;
		chk("fail_set", fail, 1'b1);
		chk("drives_off", msm, 6'h00);
		wr(`UPC_REG_THRESH, 32'd120);
		wr(`UPC_REG_CTRL, 32'h3);
		repeat (3) @(posedge core_clk);
		chk("fail_held", fail, 1'b1);
		wr(`UPC_REG_WB, 32'd10);
		repeat (9000) @(posedge core_clk);
		wr(`UPC_REG_CTRL, 32'h3);
		repeat (3) @(posedge core_clk);
		chk("fail_clear", fail, 1'b0);
		// slow converter, temperature and decimated loops
		temp_val <= 16'($urandom);
		slow <= 1'b1;
		repeat (1600) @(posedge core_clk);
		t0 = nb;
		pr = nc;
		repeat (45000) @(posedge core_clk);
		chk("bst_decim", nb - t0 <= 2, 1'b1);
		chk("chg_decim", nc - pr <= 2, 1'b1);
		rd(`UPC_REG_CHG_AVG, 32'h123);
		rd(`UPC_REG_TEMP, {16'h0, temp_val});
		repeat (3) @(posedge core_clk);
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire

/* File: tb/upc_stage_model.sv */
`default_nettype none
module upc_stage_model (
	// clock
	input  wire logic               core_clk,
	// bench control
	input  wire logic               conv_start,
	input  wire logic               slow,
	input  wire logic [15:0]        temp_val,
	// converter side
	output logic                    conv_done,
	output logic                    temp_done,
	output logic [15:0]             temp_data,
	output logic signed [15:0]      res [7]
);
	timeunit 1ns;
	timeprecision 1ps;
	int wait_n = 0;
	int hi_n = 0;

	// idle converter outputs at time zero
	initial begin
		conv_done = 1'b0;
		temp_done = 1'b0;
		temp_data = 16'h0000;
		foreach (res[i]) res[i] = 16'sh0000;
	end

	// conversion runs a short or a long time, then ends with a 3-cycle pulse
	always @(posedge core_clk) begin
		if (conv_start) begin
			wait_n <= slow ? 60 : 2;
		end else if (wait_n == 1) begin
			conv_done <= 1'b1;
			temp_done <= 1'b1;
			temp_data <= temp_val;
			foreach (res[i]) res[i] <= 16'($urandom);
			hi_n <= 3;
			wait_n <= 0;
		end else if (wait_n != 0) begin
			wait_n <= wait_n - 1;
		end
		if (hi_n == 1) begin
			conv_done <= 1'b0;
			temp_done <= 1'b0;
		end
		if (hi_n != 0) begin
			hi_n <= hi_n - 1;
		end
	end
endmodule // upc_stage_model
`default_nettype wire
